/* common/port_policy_cfg.svh */
// Offsets, field positions, reset values and timing counts for the ingress policy block.
`ifndef PORT_POLICY_CFG_SVH
`define PORT_POLICY_CFG_SVH

`define NUM_FIXED_PORTS 22
`define NUM_PORTS 24
`define PORT_SLOT_FIRST 5'h17
`define PORT_SLOT_SECOND 5'h18
`define PORT_SEL_ALL 5'h1F

`define ADDR_PORT_SEL 8'h00
`define ADDR_STAGE_CTRL 8'h04
`define ADDR_STAGE_THR 8'h08
`define ADDR_COMMIT 8'h0C
`define ADDR_PORT_STATUS 8'h10
`define ADDR_SLOT_INFO 8'h14

`define CTRL_ENABLE 0
`define CTRL_SPEED_LO 1
`define CTRL_SPEED_HI 3
`define CTRL_FC 4
`define CTRL_PRIO_LO 5
`define CTRL_PRIO_HI 6
`define CTRL_LOCK 7
`define CTRL_RISE_LO 8
`define CTRL_RISE_HI 9
`define CTRL_FALL_LO 10
`define CTRL_FALL_HI 11
`define CTRL_WIDTH 12

`define CTRL_RESET 12'h0001
`define RISE_THR_RESET 16'h01F4
`define FALL_THR_RESET 16'h0064

`define STORM_INTERVAL_MS 1000
`define REF_CLK_KHZ 50000

`endif

/* common/port_policy_pkg.sv */
// Field encodings shared by the ingress policy block and its users.
package port_policy_pkg;

  typedef enum logic [2:0] {
    SPD_AUTO = 3'h0,
    SPD_100_FULL = 3'h1,
    SPD_100_HALF = 3'h2,
    SPD_10_FULL = 3'h3,
    SPD_10_HALF = 3'h4
  } speed_e;

  typedef enum logic [1:0] {
    PRIO_NORMAL = 2'h0,
    PRIO_HIGH = 2'h1,
    PRIO_LOW = 2'h2
  } prio_e;

  typedef enum logic [1:0] {
    RISE_NOTHING = 2'h0,
    RISE_BLOCK = 2'h1,
    RISE_BLOCK_TRAP = 2'h2
  } rise_act_e;

  typedef enum logic [1:0] {
    FALL_NOTHING = 2'h0,
    FALL_FORWARD = 2'h1,
    FALL_FORWARD_TRAP = 2'h2
  } fall_act_e;

endpackage : port_policy_pkg

/* hw/switch_port_ingress_policy.sv */
// Per-port ingress policy: port state, speed, pause, queue class, lock and storm control.
`timescale 1ns/100ps
`include "port_policy_cfg.svh"
// Behaviour
// - High priority port sends every received packet to the high queue.
// - Low priority port sends every received packet to the low queue.
// - Normal port checks for a priority tag; untagged goes low.
// - Normal port: tag value 0 to 3 goes low, 4 to 7 high.
// - Low queue is served only while the high queue is empty.
// - A disabled port passes no traffic at all.
// - Speed offers auto or fixed 100/10 full/half; auto starts negotiation.
// - Flow control on a full duplex link requests pause when the buffer fills.
// - With auto speed, flow control needs partner agreement; shown in status.
// - A locked port stops learning source addresses.
// - Learned entries of a locked port still age out normally.
// - A locked port only accepts sources present in the static table.
// - Broadcasts per second are counted; reaching rising threshold fires rising action.
// - Rising action do-nothing leaves the port operating normally.
// - Blocking drops broadcasts; blocking with trap also raises a trap event.
// - Falling action fires only after rising, when rate falls to falling threshold.
// - Falling do-nothing keeps a blocking port blocking broadcasts.
// - Forwarding clears blocking; forwarding with trap also raises a trap event.
// - Configure one fixed port 1 to 22, or all fixed ports identically.
// - Two slot ports; the second only usable with a dual module fitted.
// - Spanning tree state and link status are read only.

module switch_port_ingress_policy #(
  parameter int unsigned INTERVAL_CYCLES = `STORM_INTERVAL_MS * `REF_CLK_KHZ
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic [4:0] rx_port,
  input wire logic rx_bcast,
  input wire logic rx_tagged,
  input wire logic [2:0] rx_pcp,
  input wire logic rx_src_static,
  output logic fwd_valid,
  output logic fwd_drop,
  output logic fwd_high,
  output logic fwd_learn,
  output logic [4:0] fwd_port,
  input wire logic high_queue_pending,
  input wire logic low_queue_pending,
  output logic serve_high,
  output logic serve_low,
  input wire logic [23:0] link_up,
  input wire logic [23:0] link_full_duplex,
  input wire logic [23:0] partner_pause_able,
  input wire logic [23:0] stp_forwarding,
  input wire logic [23:0] rx_buffer_high,
  input wire logic dual_module_pin,
  output logic [23:0] port_enabled,
  output logic [23:0] autoneg_enable,
  output logic [23:0] autoneg_restart,
  output logic [23:0] force_speed_100,
  output logic [23:0] force_full_duplex,
  output logic [23:0] pause_request,
  output logic [23:0] storm_trap
);

  // Decodes whether a committed selection addresses port index idx.
  function automatic logic sel_hits(input logic [4:0] sel, input int idx, input logic dual);
    logic hit;
    hit = 1'b0;
    if (sel == `PORT_SEL_ALL) begin
      hit = (idx < `NUM_FIXED_PORTS);
    end else if (sel == `PORT_SLOT_SECOND) begin
      hit = dual && (idx == 23);
    end else if (sel != 5'h00) begin
      hit = (32'(sel) == 32'(idx + 1));
    end
    return hit;
  endfunction : sel_hits

  function automatic logic sel_valid(input logic [4:0] sel, input logic dual);
    logic ok;
    ok = (sel == `PORT_SEL_ALL) || ((sel != 5'h00) && (sel <= `PORT_SLOT_FIRST));
    if (sel == `PORT_SLOT_SECOND) begin
      ok = dual;
    end
    return ok;
  endfunction : sel_valid

  ////////////////////////////////////////////////////////////////////////////////
  // Strap-like pin from the slot connector, synchronised over three stages.

  logic [2:0] dual_sync_ff;
  logic dual_fitted_ff;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      dual_sync_ff <= 3'h0;
    end else begin
      dual_sync_ff <= {dual_sync_ff[1:0], dual_module_pin};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      dual_fitted_ff <= 1'b0;
    end else if (dual_sync_ff[2] == dual_sync_ff[1]) begin
      dual_fitted_ff <= dual_sync_ff[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Staging registers and the commit strobe.

  logic [4:0] port_sel_ff;
  logic [`CTRL_WIDTH-1:0] stage_ctrl_ff;
  logic [31:0] stage_thr_ff;
  logic commit_reject_ff;
  logic commit;
  logic [`CTRL_WIDTH-1:0] cfg_ctrl [`NUM_PORTS];
  logic [31:0] cfg_thr [`NUM_PORTS];
  logic [4:0] view_idx;

  assign commit = reg_wr && (reg_addr == `ADDR_COMMIT);
  assign view_idx = ((port_sel_ff == 5'h00) || (port_sel_ff > `PORT_SLOT_SECOND)) ?
                    5'h00 : 5'(port_sel_ff - 5'h01);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      port_sel_ff <= 5'h01;
    end else if (reg_wr && (reg_addr == `ADDR_PORT_SEL)) begin
      port_sel_ff <= reg_wdata[4:0];
    end
  end

  // Edits live only here until commit, so a half-edited port never sees a mix.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      stage_ctrl_ff <= `CTRL_RESET;
      stage_thr_ff <= {`RISE_THR_RESET, `FALL_THR_RESET};
    end else begin
      if (reg_wr && (reg_addr == `ADDR_STAGE_CTRL)) begin
        stage_ctrl_ff <= reg_wdata[`CTRL_WIDTH-1:0];
      end
      if (reg_wr && (reg_addr == `ADDR_STAGE_THR)) begin
        stage_thr_ff <= reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      commit_reject_ff <= 1'b0;
    end else if (commit) begin
      commit_reject_ff <= !sel_valid(port_sel_ff, dual_fitted_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One second interval divider.

  logic [31:0] div_ff;
  logic interval_end;

  assign interval_end = (div_ff == INTERVAL_CYCLES - 32'h0000_0001);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      div_ff <= 32'h0000_0000;
    end else if (interval_end) begin
      div_ff <= 32'h0000_0000;
    end else begin
      div_ff <= div_ff + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-port configuration, pause and storm control.

  logic [23:0] fc_active;
  logic [23:0] storm_armed;
  logic [23:0] bcast_block;

  for (genvar i = 0; i < `NUM_PORTS; i++) begin : g_port
    logic [`CTRL_WIDTH-1:0] ctrl_ff;
    logic [31:0] thr_ff;
    logic [15:0] bcast_cnt_ff;
    logic armed_ff;
    logic block_ff;
    logic trap_ff;
    logic restart_ff;
    logic pause_ff;
    logic hit;
    logic rx_here;
    logic [15:0] rise_thr;
    logic [15:0] fall_thr;
    logic auto_mode;
    port_policy_pkg::rise_act_e rise_act;
    port_policy_pkg::fall_act_e fall_act;

    assign hit = commit && sel_hits(port_sel_ff, i, dual_fitted_ff);
    assign rx_here = rx_valid && rx_bcast && (32'(rx_port) == 32'(i + 1));
    assign rise_thr = thr_ff[31:16];
    assign fall_thr = thr_ff[15:0];
    assign rise_act = port_policy_pkg::rise_act_e'(ctrl_ff[`CTRL_RISE_HI:`CTRL_RISE_LO]);
    assign fall_act = port_policy_pkg::fall_act_e'(ctrl_ff[`CTRL_FALL_HI:`CTRL_FALL_LO]);
    assign auto_mode = (ctrl_ff[`CTRL_SPEED_HI:`CTRL_SPEED_LO] == port_policy_pkg::SPD_AUTO);

    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        ctrl_ff <= `CTRL_RESET;
        thr_ff <= {`RISE_THR_RESET, `FALL_THR_RESET};
      end else if (hit) begin
        ctrl_ff <= stage_ctrl_ff;
        thr_ff <= stage_thr_ff;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        restart_ff <= 1'b0;
      end else begin
        restart_ff <= hit && stage_ctrl_ff[`CTRL_ENABLE] &&
                      (stage_ctrl_ff[`CTRL_SPEED_HI:`CTRL_SPEED_LO] ==
                       port_policy_pkg::SPD_AUTO);
      end
    end

    // With auto speed the pause ability must also come from the partner.
    assign fc_active[i] = ctrl_ff[`CTRL_ENABLE] && ctrl_ff[`CTRL_FC] && link_up[i] &&
                          link_full_duplex[i] &&
                          (!auto_mode || partner_pause_able[i]);

    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        pause_ff <= 1'b0;
      end else begin
        pause_ff <= fc_active[i] && rx_buffer_high[i];
      end
    end

    // A packet that lands on the interval edge opens the next count.
    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        bcast_cnt_ff <= 16'h0000;
      end else if (interval_end) begin
        bcast_cnt_ff <= {15'h0000, rx_here};
      end else if (rx_here && (bcast_cnt_ff != 16'hFFFF)) begin
        bcast_cnt_ff <= bcast_cnt_ff + 16'h0001;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (!resetn) begin
        armed_ff <= 1'b0;
        block_ff <= 1'b0;
        trap_ff <= 1'b0;
      end else begin
        trap_ff <= 1'b0;
        if (interval_end) begin
          if (!armed_ff && (bcast_cnt_ff >= rise_thr)) begin
            armed_ff <= 1'b1;
            case (rise_act)
              port_policy_pkg::RISE_BLOCK: begin
                block_ff <= 1'b1;
              end
              port_policy_pkg::RISE_BLOCK_TRAP: begin
                block_ff <= 1'b1;
                trap_ff <= 1'b1;
              end
              default: begin
                block_ff <= block_ff;
              end
            endcase
          end else if (armed_ff && (bcast_cnt_ff <= fall_thr)) begin
            armed_ff <= 1'b0;
            case (fall_act)
              port_policy_pkg::FALL_FORWARD: begin
                block_ff <= 1'b0;
              end
              port_policy_pkg::FALL_FORWARD_TRAP: begin
                block_ff <= 1'b0;
                trap_ff <= 1'b1;
              end
              default: begin
                block_ff <= block_ff;
              end
            endcase
          end
        end
      end
    end

    assign cfg_ctrl[i] = ctrl_ff;
    assign cfg_thr[i] = thr_ff;
    assign storm_armed[i] = armed_ff;
    assign bcast_block[i] = block_ff;
    assign autoneg_restart[i] = restart_ff;
    assign pause_request[i] = pause_ff;
    assign storm_trap[i] = trap_ff;
    assign port_enabled[i] = ctrl_ff[`CTRL_ENABLE];
    assign autoneg_enable[i] = ctrl_ff[`CTRL_ENABLE] && auto_mode;
    assign force_speed_100[i] = (ctrl_ff[`CTRL_SPEED_HI:`CTRL_SPEED_LO] ==
                                 port_policy_pkg::SPD_100_FULL) ||
                                (ctrl_ff[`CTRL_SPEED_HI:`CTRL_SPEED_LO] ==
                                 port_policy_pkg::SPD_100_HALF);
    assign force_full_duplex[i] = (ctrl_ff[`CTRL_SPEED_HI:`CTRL_SPEED_LO] ==
                                   port_policy_pkg::SPD_100_FULL) ||
                                  (ctrl_ff[`CTRL_SPEED_HI:`CTRL_SPEED_LO] ==
                                   port_policy_pkg::SPD_10_FULL);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Ingress decision, one registered answer per received descriptor.

  logic [4:0] rx_idx;
  logic port_ok;
  logic [`CTRL_WIDTH-1:0] rx_ctrl;
  logic rx_locked;
  logic drop;
  logic high;
  port_policy_pkg::prio_e rx_prio;

  assign port_ok = (rx_port != 5'h00) && (rx_port <= `PORT_SLOT_SECOND) &&
                   ((rx_port != `PORT_SLOT_SECOND) || dual_fitted_ff);
  assign rx_idx = port_ok ? 5'(rx_port - 5'h01) : 5'h00;
  assign rx_ctrl = cfg_ctrl[rx_idx];
  assign rx_locked = rx_ctrl[`CTRL_LOCK];
  assign rx_prio = port_policy_pkg::prio_e'(rx_ctrl[`CTRL_PRIO_HI:`CTRL_PRIO_LO]);

  always_comb begin
    drop = !port_ok || !rx_ctrl[`CTRL_ENABLE];
    if (rx_locked && !rx_src_static) begin
      drop = 1'b1;
    end
    if (rx_bcast && bcast_block[rx_idx]) begin
      drop = 1'b1;
    end
  end

  always_comb begin
    case (rx_prio)
      port_policy_pkg::PRIO_HIGH: begin
        high = 1'b1;
      end
      port_policy_pkg::PRIO_LOW: begin
        high = 1'b0;
      end
      default: begin
        high = rx_tagged && rx_pcp[2];
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fwd_valid <= 1'b0;
      fwd_drop <= 1'b0;
      fwd_high <= 1'b0;
      fwd_learn <= 1'b0;
      fwd_port <= 5'h00;
    end else begin
      fwd_valid <= rx_valid;
      fwd_drop <= rx_valid && drop;
      fwd_high <= rx_valid && !drop && high;
      // Locking stops new learning and drops non-static sources; the aging engine is left untouched.
      fwd_learn <= rx_valid && !drop && !rx_locked;
      fwd_port <= rx_port;
    end
  end

  // Strict priority: the low queue waits on any pending high packet.
  assign serve_high = high_queue_pending;
  assign serve_low = low_queue_pending && !high_queue_pending;

  ////////////////////////////////////////////////////////////////////////////////
  // Register read port; status words ignore writes entirely.

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_PORT_SEL: begin
          reg_rdata <= {27'h000_0000, port_sel_ff};
        end
        `ADDR_STAGE_CTRL: begin
          reg_rdata <= {20'h0_0000, stage_ctrl_ff};
        end
        `ADDR_STAGE_THR: begin
          reg_rdata <= stage_thr_ff;
        end
        `ADDR_COMMIT: begin
          reg_rdata <= {31'h0000_0000, commit_reject_ff};
        end
        `ADDR_PORT_STATUS: begin
          // Only the low twelve bits of the rising threshold fit beside the control word.
          reg_rdata <= {cfg_thr[view_idx][27:16], cfg_ctrl[view_idx],
                        1'b0, bcast_block[view_idx], storm_armed[view_idx],
                        fc_active[view_idx], stp_forwarding[view_idx],
                        link_full_duplex[view_idx], link_up[view_idx],
                        autoneg_enable[view_idx]};
        end
        `ADDR_SLOT_INFO: begin
          reg_rdata <= {31'h0000_0000, dual_fitted_ff};
        end
        default: begin
          reg_rdata <= 32'h0000_0000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : switch_port_ingress_policy

/* verif/port_policy_assertions.sv */
// Concurrent checks on the ports of the ingress policy block.
`timescale 1ns/100ps
module port_policy_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic [4:0] rx_port,
  input wire logic fwd_valid,
  input wire logic fwd_drop,
  input wire logic fwd_learn,
  input wire logic [4:0] fwd_port,
  input wire logic high_queue_pending,
  input wire logic low_queue_pending,
  input wire logic serve_high,
  input wire logic serve_low,
  input wire logic [23:0] link_full_duplex,
  input wire logic [23:0] rx_buffer_high,
  input wire logic [23:0] port_enabled,
  input wire logic [23:0] autoneg_enable,
  input wire logic [23:0] autoneg_restart,
  input wire logic [23:0] pause_request,
  input wire logic [23:0] storm_trap
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_fwd_answer;
    rx_valid |=> fwd_valid && fwd_port == $past(rx_port);
  endproperty
  a_fwd_answer: assert property (p_fwd_answer) else $error("packet got no answer");
  property p_off_drop;
    rx_valid && rx_port inside {[1:24]} && !port_enabled[rx_port - 5'd1] |=> fwd_drop;
  endproperty
  a_off_drop: assert property (p_off_drop) else $error("disabled port passed");
  property p_bad_port;
    rx_valid && (rx_port == 5'h00 || rx_port > 5'h18) |=> fwd_drop;
  endproperty
  a_bad_port: assert property (p_bad_port) else $error("bad port passed");
  property p_high_first;
    high_queue_pending |-> serve_high && !serve_low;
  endproperty
  a_high_first: assert property (p_high_first) else $error("low served first");
  property p_low_served;
    !high_queue_pending && low_queue_pending |-> serve_low;
  endproperty
  a_low_served: assert property (p_low_served) else $error("low not served");
  // Pause may only follow a full buffer on a full duplex link one cycle earlier.
  property p_pause_cause;
    (pause_request & ~($past(rx_buffer_high) & $past(link_full_duplex))) == 24'h00_0000;
  endproperty
  a_pause_cause: assert property (p_pause_cause) else $error("pause without cause");
  property p_trap_pulse;
    (storm_trap & $past(storm_trap)) == 24'h00_0000;
  endproperty
  a_trap_pulse: assert property (p_trap_pulse) else $error("trap longer than a pulse");
  property p_restart_auto;
    (autoneg_restart & ~autoneg_enable) == 24'h00_0000;
  endproperty
  a_restart_auto: assert property (p_restart_auto) else $error("restart without auto");
  property p_drop_nolearn;
    fwd_drop |-> fwd_valid && !fwd_learn;
  endproperty
  a_drop_nolearn: assert property (p_drop_nolearn) else $error("dropped source learned");
  c_trap: cover property (|storm_trap);
  c_drop: cover property (rx_valid ##1 fwd_drop);
  c_low: cover property (serve_low);
  c_restart: cover property (|autoneg_restart);
endmodule : port_policy_checker

bind switch_port_ingress_policy port_policy_checker u_chk (.*);

/* verif/link_partner_model.sv */
// Line-side stations: report link state and hand frame descriptors to the block.
`timescale 1ns/100ps
module link_partner_model (
  input wire logic ref_clk,
  output logic [23:0] link_up,
  output logic [23:0] link_full_duplex,
  output logic [23:0] partner_pause_able,
  output logic rx_valid,
  output logic [4:0] rx_port,
  output logic rx_bcast,
  output logic rx_tagged,
  output logic [2:0] rx_pcp,
  output logic rx_src_static
);
  logic [23:0] fdx = 24'hFF_FFFF;
  logic [23:0] pause = 24'h00_0000;
  assign link_up = 24'hFF_FFFF;
  assign link_full_duplex = fdx;
  assign partner_pause_able = pause;
  initial {rx_valid, rx_port, rx_bcast, rx_tagged, rx_pcp, rx_src_static} = 12'h000;
  // Fields are inverted between frames so a stale value is never read as valid.
  task automatic send(input logic [4:0] p, input logic b, t, input logic [2:0] c, input logic s);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    {rx_port, rx_bcast, rx_tagged, rx_pcp, rx_src_static} <= {p, b, t, c, s};
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    {rx_port, rx_bcast, rx_tagged, rx_pcp, rx_src_static} <= ~{p, b, t, c, s};
  endtask : send
endmodule : link_partner_model

/* verif/tb_top.sv */
// Self-checking bench for the ingress policy block.
`timescale 1ns/100ps
`include "port_policy_cfg.svh"
module tb_top;
  logic ref_clk = 0;
  logic resetn = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic high_queue_pending = 0;
  logic low_queue_pending = 0;
  logic dual_module_pin = 0;
  logic [23:0] stp_forwarding = 24'h00_0001;
  logic [23:0] rx_buffer_high = 24'h00_0000;
  logic [23:0] trap_seen = 24'h00_0000;
  logic [31:0] reg_rdata;
  logic rx_valid, rx_bcast, rx_tagged, rx_src_static, serve_high, serve_low;
  logic fwd_valid, fwd_drop, fwd_high, fwd_learn;
  logic [4:0] rx_port, fwd_port;
  logic [2:0] rx_pcp;
  logic [23:0] link_up, link_full_duplex, partner_pause_able, port_enabled, autoneg_enable;
  logic [23:0] autoneg_restart, force_speed_100, force_full_duplex, pause_request, storm_trap;
  int n_errors = 0;
  int checks = 0;

  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) trap_seen <= trap_seen | storm_trap;
  // A short storm interval keeps each measured second to 64 cycles.
  switch_port_ingress_policy #(.INTERVAL_CYCLES(64)) u_dut (.*);
  link_partner_model u_lp (.*);

  ////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  function automatic logic [31:0] cw(input logic [1:0] p, ra, fa, input logic fc, lk,
      input logic [2:0] s);
    return {20'h0_0000, fa, ra, lk, p, fc, s, 1'b1};
  endfunction : cw
  task automatic cfg(input logic [4:0] p, input logic [31:0] c, input logic [31:0] thr);
    wr(`ADDR_PORT_SEL, {27'h000_0000, p});
    wr(`ADDR_STAGE_CTRL, c);
    wr(`ADDR_STAGE_THR, thr);
    wr(`ADDR_COMMIT, 32'h0000_0000);
  endtask : cfg
  // A dropped packet has no meaningful queue class, so only valid and drop are judged then.
  task automatic pkt(input logic [4:0] p, input logic b, t, input logic [2:0] c, input logic s,
      input logic [1:0] exp);
    u_lp.send(p, b, t, c, s);
    #1 chk({29'h0, fwd_valid, fwd_drop, fwd_high & !exp[1]}, {29'h0, 1'b1, exp});
  endtask : pkt
  task automatic wait_trap(input int b);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (storm_trap[b] !== 1'b1 && n < 300);
    if (storm_trap[b] !== 1'b1) begin
      n_errors++;
      give_verdict;
    end
  endtask : wait_trap

  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({8'h00, port_enabled}, 32'h00FF_FFFF);
    rd(`ADDR_STAGE_CTRL, 32'h0000_0001);
    rd(`ADDR_STAGE_THR, 32'h01F4_0064);
    rd(8'h20, 32'h0000_0000);
    wr(`ADDR_PORT_STATUS, 32'hFFFF_FFFF);
    rd(`ADDR_PORT_STATUS, 32'h1F40_010F);
    rd(`ADDR_SLOT_INFO, 32'h0000_0000);
  endtask : t_reset
  task automatic t_queue;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      {high_queue_pending, low_queue_pending} <= 2'(i);
      @(posedge ref_clk);
      #1 chk({serve_high, serve_low}, {i[1], !i[1] && i[0]});
    end
  endtask : t_queue
  task automatic t_prio;
    cfg(5'd3, cw(port_policy_pkg::PRIO_HIGH, 0, 0, 0, 0, 0), 32'h01F4_0064);
    pkt(5'd3, 0, 1, 3'h0, 0, 2'b01);
    cfg(5'd3, cw(port_policy_pkg::PRIO_LOW, 0, 0, 0, 0, 0), 32'h01F4_0064);
    pkt(5'd3, 0, 1, 3'h7, 0, 2'b00);
    cfg(5'd3, cw(port_policy_pkg::PRIO_NORMAL, 0, 0, 0, 0, 0), 32'h01F4_0064);
    pkt(5'd3, 0, 0, 3'h7, 0, 2'b00);
    for (int i = 0; i < 8; i++) begin
      pkt(5'd3, 0, 1, 3'(i), 0, {1'b0, i >= 4});
    end
    chk({31'h0, fwd_learn}, 32'h0000_0001);
  endtask : t_prio
  task automatic t_lock;
    cfg(5'd2, cw(0, 0, 0, 0, 1, 0), 32'h01F4_0064);
    pkt(5'd2, 0, 0, 3'h0, 1, 2'b00);
    chk({31'h0, fwd_learn}, 32'h0000_0000);
    pkt(5'd2, 0, 0, 3'h0, 0, 2'b10);
  endtask : t_lock
  task automatic t_pause;
    cfg(5'd6, cw(0, 0, 0, 1, 0, port_policy_pkg::SPD_100_FULL), 32'h01F4_0064);
    #1 chk({force_speed_100[5], force_full_duplex[5], autoneg_enable[5]}, 3'b110);
    @(posedge ref_clk);
    rx_buffer_high <= 24'h00_0020;
    repeat (2) @(posedge ref_clk);
    #1 chk({31'h0, pause_request[5]}, 32'h0000_0001);
    cfg(5'd6, cw(0, 0, 0, 1, 0, port_policy_pkg::SPD_AUTO), 32'h01F4_0064);
    #1 chk({31'h0, autoneg_restart[5]}, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    #1 chk({31'h0, pause_request[5]}, 32'h0000_0000);
    @(posedge ref_clk);
    u_lp.pause <= 24'hFF_FFFF;
    repeat (2) @(posedge ref_clk);
    #1 chk({31'h0, pause_request[5]}, 32'h0000_0001);
    wr(`ADDR_PORT_SEL, 32'h0000_0006);
    rd(`ADDR_PORT_STATUS, 32'h1F40_1117);
    @(posedge ref_clk);
    u_lp.fdx <= 24'hFF_FFDF;
    repeat (2) @(posedge ref_clk);
    #1 chk({31'h0, pause_request[5]}, 32'h0000_0000);
    @(posedge ref_clk);
    u_lp.fdx <= 24'hFF_FFFF;
    rx_buffer_high <= 24'h00_0000;
  endtask : t_pause
  task automatic t_storm;
    cfg(5'd4, cw(0, 2'h2, 2'h2, 0, 0, 0), 32'h0003_0001);
    cfg(5'd7, cw(0, 2'h1, 2'h0, 0, 0, 0), 32'h0003_0001);
    cfg(5'd8, cw(0, 2'h0, 2'h1, 0, 0, 0), 32'h0003_0001);
    for (int i = 0; i < 8; i++) begin
      u_lp.send(5'd4, 1, 0, 3'h0, 0);
      u_lp.send(5'd7, 1, 0, 3'h0, 0);
      u_lp.send(5'd8, 1, 0, 3'h0, 0);
    end
    wait_trap(3);
    pkt(5'd4, 1, 0, 3'h0, 0, 2'b10);
    pkt(5'd4, 0, 0, 3'h0, 0, 2'b00);
    wait_trap(3);
    pkt(5'd4, 1, 0, 3'h0, 0, 2'b00);
    repeat (200) @(posedge ref_clk);
    pkt(5'd7, 1, 0, 3'h0, 0, 2'b10);
    pkt(5'd8, 1, 0, 3'h0, 0, 2'b00);
    chk({8'h00, trap_seen}, 32'h0000_0008);
  endtask : t_storm
  task automatic t_slot;
    pkt(5'd24, 0, 0, 3'h0, 0, 2'b10);
    cfg(5'd24, 32'h0000_0000, 32'h01F4_0064);
    rd(`ADDR_COMMIT, 32'h0000_0001);
    @(posedge ref_clk);
    dual_module_pin <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd(`ADDR_SLOT_INFO, 32'h0000_0001);
    pkt(5'd24, 0, 0, 3'h0, 0, 2'b00);
    pkt(5'd23, 0, 0, 3'h0, 0, 2'b00);
  endtask : t_slot
  task automatic t_all;
    cfg(`PORT_SEL_ALL, 32'h0000_0000, 32'h01F4_0064);
    #1 chk({8'h00, port_enabled}, 32'h00C0_0000);
    pkt(5'd5, 0, 0, 3'h0, 0, 2'b10);
    pkt(5'd0, 0, 0, 3'h0, 0, 2'b10);
    pkt(5'd25, 0, 0, 3'h0, 0, 2'b10);
  endtask : t_all

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    #1 t_reset();
    t_queue();
    t_prio();
    t_lock();
    t_pause();
    t_storm();
    t_slot();
    t_all();
    give_verdict();
  end
endmodule : tb_top
